// ### core/sls_pkg.sv
// Purpose: Shared constants and types for the status indicator blink-code signaller
// Assumes: 25 MHz system clock
// Notes:   All timing counts derive from times in milliseconds
package sls_pkg;

  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned SEP_MS         = 3000;
  localparam int unsigned LONG_MS        = 1000;
  localparam int unsigned SHORT_MS       = 200;
  localparam int unsigned FAST_MS        = 100;
  localparam int unsigned SEP_CYC        = CLK_HZ / 1000 * SEP_MS;
  localparam int unsigned LONG_CYC       = CLK_HZ / 1000 * LONG_MS;
  localparam int unsigned SHORT_CYC      = CLK_HZ / 1000 * SHORT_MS;
  localparam int unsigned FAST_CYC       = CLK_HZ / 1000 * FAST_MS;
  localparam int unsigned TMR_W          = 27;

  localparam logic [3:0]  DIGIT_MIN      = 4'h1;
  localparam logic [3:0]  DIGIT_MAX      = 4'h9;
  localparam logic [6:0]  ERR_MIN        = 7'h0B;
  localparam logic [6:0]  ERR_MAX        = 7'h63;

  // Indicator colour drive: red bit, yellow bit
  typedef struct packed {
    logic red;
    logic yellow;
  } sls_colour_t;

  localparam sls_colour_t COL_RED    = 2'h2;
  localparam sls_colour_t COL_YELLOW = 2'h1;
  localparam sls_colour_t COL_OFF    = 2'h0;

  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] ones;
  } sls_code_t;

  typedef enum logic [4:0] {
    ST_SEP   = 5'h01,
    ST_LRED  = 5'h02,
    ST_LYEL  = 5'h04,
    ST_SRED  = 5'h08,
    ST_SYEL  = 5'h10
  } sls_state_t;

  // Split a binary error number into two decimal digits
  function automatic sls_code_t sls_split(input logic [6:0] num);
    sls_code_t c;
    logic [6:0] t;
    t = num / 7'h0A;
    c.tens = t[3:0];
    c.ones = 4'(num - 7'(t * 7'h0A));
    return c;
  endfunction

  function automatic logic sls_code_ok(input logic [6:0] num);
    sls_code_t c;
    c = sls_split(num);
    return (num >= ERR_MIN) && (num <= ERR_MAX) && (c.tens != 4'h0) && (c.ones != 4'h0);
  endfunction

endpackage

// ### core/sls_timer.sv
// Purpose: Reloadable down-counter giving a one-cycle expiry pulse
// Assumes: Load wins over counting
// Notes:   Expiry fires when count reaches one, so a load of N lasts N cycles
`timescale 1ns/100ps
`default_nettype none
module sls_timer
  import sls_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_val,
  output var  logic             expired
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg > TMR_W'(1)) begin
      cnt_next = cnt_reg - TMR_W'(1);
    end else begin
      cnt_next = TMR_W'(0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Expiry reads only the count, so a caller may reload on it without a loop
  assign expired = (cnt_reg == TMR_W'(1));

endmodule
`default_nettype wire

// ### core/sls_fast_osc.sv
// Purpose: Fast red/yellow alternation source for busy displays
// Assumes: Free running from reset
// Notes:   Phase toggles every FAST_CYC cycles
`timescale 1ns/100ps
`default_nettype none
module sls_fast_osc
  import sls_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  output var  logic phase
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;
  logic             phase_reg;
  logic             phase_next;

  // Own down-counter, reloaded at zero, so every phase lasts FAST_CYC cycles
  always_comb begin
    cnt_next   = cnt_reg - TMR_W'(1);
    phase_next = phase_reg;
    if (cnt_reg == '0) begin
      cnt_next   = TMR_W'(FAST_CYC - 1);
      phase_next = !phase_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= TMR_W'(FAST_CYC - 1);
      phase_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;

endmodule
`default_nettype wire

// ### core/sls_status_led.sv
// Purpose: Status indicator driver with busy, ready, fatal and blink-code displays
// Assumes: Status inputs come from logic on CLK; no synchronisers needed
// Notes:   Priority fatal > error code > busy > ready
`timescale 1ns/100ps
`default_nettype none
module sls_status_led
  import sls_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SELF_TEST_BUSY,
  input  wire logic       NET_ACQ_BUSY,
  input  wire logic       NET_CFG_MODE,
  input  wire logic       FATAL_ERR,
  input  wire logic       ERR_VALID,
  input  wire logic [6:0] ERR_NUM,
  input  wire logic       ERR_LOAD,
  output var  logic       STATUS_INDICATOR_RED,
  output var  logic       STATUS_INDICATOR_YELLOW,
  output var  logic       CODE_ACTIVE,
  output var  logic       CODE_REJECT
);

  sls_state_t       state_reg;
  sls_state_t       state_next;
  sls_code_t        code_reg;
  sls_code_t        code_next;
  logic             code_ok_reg;
  logic             code_ok_next;
  logic [3:0]       left_reg;
  logic [3:0]       left_next;
  logic             reject_reg;
  logic             reject_next;
  sls_colour_t      col_reg;
  sls_colour_t      col_next;
  logic             active_reg;
  logic             active_next;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_exp;
  logic             fast_phase;
  logic             show_code;

  sls_timer u_step_tmr (
    .clk      (CLK),
    .rst      (SYS_RST),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_exp)
  );

  sls_fast_osc u_fast (
    .clk   (CLK),
    .rst   (SYS_RST),
    .phase (fast_phase)
  );

  assign show_code = ERR_VALID && code_ok_reg;

  // Code capture; rejected numbers are never shown
  always_comb begin
    code_next    = code_reg;
    code_ok_next = code_ok_reg;
    reject_next  = 1'b0;
    if (ERR_LOAD) begin
      if (sls_code_ok(ERR_NUM)) begin
        code_next    = sls_split(ERR_NUM);
        code_ok_next = 1'b1;
      end else begin
        code_ok_next = 1'b0;
        reject_next  = 1'b1;
      end
    end
  end

  // Blink-code sequencer
  always_comb begin
    state_next = state_reg;
    left_next  = left_reg;
    tmr_load   = 1'b0;
    tmr_val    = TMR_W'(SEP_CYC);
    if (ERR_LOAD || !show_code) begin
      // Restart so a new code is never shown mid-sequence
      state_next = ST_SEP;
      tmr_load   = 1'b1;
      tmr_val    = TMR_W'(SEP_CYC);
    end else if (tmr_exp) begin
      tmr_load = 1'b1;
      unique case (state_reg)
        ST_SEP: begin
          state_next = ST_LRED;
          left_next  = code_reg.tens;
          tmr_val    = TMR_W'(LONG_CYC);
        end
        ST_LRED: begin
          state_next = ST_LYEL;
          tmr_val    = TMR_W'(LONG_CYC);
        end
        ST_LYEL: begin
          if (left_reg > DIGIT_MIN) begin
            state_next = ST_LRED;
            left_next  = left_reg - 4'h1;
            tmr_val    = TMR_W'(LONG_CYC);
          end else begin
            state_next = ST_SRED;
            left_next  = code_reg.ones;
            tmr_val    = TMR_W'(SHORT_CYC);
          end
        end
        ST_SRED: begin
          state_next = ST_SYEL;
          tmr_val    = TMR_W'(SHORT_CYC);
        end
        ST_SYEL: begin
          if (left_reg > DIGIT_MIN) begin
            state_next = ST_SRED;
            left_next  = left_reg - 4'h1;
            tmr_val    = TMR_W'(SHORT_CYC);
          end else begin
            state_next = ST_SEP;
            tmr_val    = TMR_W'(SEP_CYC);
          end
        end
        default: begin
          state_next = ST_SEP;
          tmr_val    = TMR_W'(SEP_CYC);
        end
      endcase
    end
  end

  // Display select
  always_comb begin
    active_next = 1'b0;
    if (FATAL_ERR) begin
      col_next = COL_RED;
    end else if (show_code) begin
      active_next = 1'b1;
      if (state_reg == ST_LRED || state_reg == ST_SRED) begin
        col_next = COL_RED;
      end else begin
        col_next = COL_YELLOW;
      end
    end else if (SELF_TEST_BUSY || NET_ACQ_BUSY || NET_CFG_MODE) begin
      col_next = fast_phase ? COL_RED : COL_YELLOW;
    end else begin
      col_next = COL_YELLOW;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg   <= ST_SEP;
      code_reg    <= '0;
      code_ok_reg <= 1'b0;
      left_reg    <= 4'h0;
      reject_reg  <= 1'b0;
      col_reg     <= COL_OFF;
      active_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      code_reg    <= code_next;
      code_ok_reg <= code_ok_next;
      left_reg    <= left_next;
      reject_reg  <= reject_next;
      col_reg     <= col_next;
      active_reg  <= active_next;
    end
  end

  assign STATUS_INDICATOR_RED    = col_reg.red;
  assign STATUS_INDICATOR_YELLOW = col_reg.yellow;
  assign CODE_ACTIVE             = active_reg;
  assign CODE_REJECT             = reject_reg;

endmodule
`default_nettype wire

// ### test/sls_status_led_monitor.sv
// Purpose: Port checker for sls_status_led
// Assumes: One clock, async high reset
// Notes:   Flash phases outlast a short run
`timescale 1ns/100ps
`default_nettype none
module sls_status_led_monitor (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       SELF_TEST_BUSY,
  input wire logic       NET_ACQ_BUSY,
  input wire logic       NET_CFG_MODE,
  input wire logic       FATAL_ERR,
  input wire logic       ERR_VALID,
  input wire logic [6:0] ERR_NUM,
  input wire logic       ERR_LOAD,
  input wire logic       STATUS_INDICATOR_RED,
  input wire logic       STATUS_INDICATOR_YELLOW,
  input wire logic       CODE_ACTIVE,
  input wire logic       CODE_REJECT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic       r;
  logic       y;
  logic       ok;
  logic       busy;
  logic       hold;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  assign r = STATUS_INDICATOR_RED;
  assign y = STATUS_INDICATOR_YELLOW;
  assign ok = ERR_NUM >= 7'h0B && ERR_NUM <= 7'h63 && ERR_NUM % 7'h0A != 7'h00;
  assign busy = SELF_TEST_BUSY || NET_ACQ_BUSY || NET_CFG_MODE;
  assign hold = ERR_VALID && !FATAL_ERR;
  // Counts up to FF, then clears to 00, long before the separator ends
  always_comb begin
    cnt_next = 8'h00;
    if (ERR_LOAD && ok && hold) begin
      cnt_next = 8'h01;
    end else if (hold && !ERR_LOAD && cnt_reg != 8'h00 && cnt_reg != 8'hFF) begin
      cnt_next = cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  sequence s_idle;
    !busy && !FATAL_ERR && !ERR_VALID;
  endsequence
  sequence s_busy;
    busy && !FATAL_ERR && !ERR_VALID;
  endsequence
  chk_fatal_red: assert property (FATAL_ERR [*2] |-> r && !y)
    else $error("fatal not red");
  chk_good_take: assert property (ERR_LOAD && ok |=> !CODE_REJECT)
    else $error("good code refused");
  chk_bad_reject: assert property (ERR_LOAD && !ok |=> CODE_REJECT)
    else $error("bad code taken");
  chk_reject_cause: assert property (CODE_REJECT |-> $past(ERR_LOAD))
    else $error("reject without load");
  chk_bad_clear: assert property (ERR_LOAD && !ok ##1 !ERR_LOAD [*2] |-> !CODE_ACTIVE)
    else $error("bad code shown");
  chk_sep_yellow: assert property (cnt_reg >= 8'h03 |-> y && !r && CODE_ACTIVE)
    else $error("separator not yellow");
  chk_ready_yel: assert property (s_idle ##1 s_idle |-> y && !r)
    else $error("ready not yellow");
  chk_busy_one: assert property (s_busy ##1 s_busy |-> r != y)
    else $error("busy colour wrong");
  chk_code_off: assert property (!ERR_VALID [*2] |-> !CODE_ACTIVE)
    else $error("code shown unasked");
endmodule
bind sls_status_led sls_status_led_monitor u_mon (
  .CLK(CLK), .SYS_RST(SYS_RST), .SELF_TEST_BUSY(SELF_TEST_BUSY),
  .NET_ACQ_BUSY(NET_ACQ_BUSY), .NET_CFG_MODE(NET_CFG_MODE), .FATAL_ERR(FATAL_ERR),
  .ERR_VALID(ERR_VALID), .ERR_NUM(ERR_NUM), .ERR_LOAD(ERR_LOAD),
  .STATUS_INDICATOR_RED(STATUS_INDICATOR_RED),
  .STATUS_INDICATOR_YELLOW(STATUS_INDICATOR_YELLOW),
  .CODE_ACTIVE(CODE_ACTIVE), .CODE_REJECT(CODE_REJECT)
);
`default_nettype wire

// ### test/sls_status_led_bench.sv
// Purpose: Self-checking bench for sls_status_led
// Assumes: Flash phases outlast this run
// Notes:   Phase timing is checked by neither this bench nor the checker
`timescale 1ns/100ps
`default_nettype none
module sls_status_led_bench
  import sls_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       st;
  logic       acq;
  logic       cfg;
  logic       fat;
  logic       ev;
  logic [6:0] num;
  logic       ld;
  logic       red;
  logic       yel;
  logic       act;
  logic       rej;
  int         errors = 0;
  int         total_checks = 0;

  sls_status_led u_dut (
    .CLK(clk), .SYS_RST(rst), .SELF_TEST_BUSY(st), .NET_ACQ_BUSY(acq),
    .NET_CFG_MODE(cfg), .FATAL_ERR(fat), .ERR_VALID(ev), .ERR_NUM(num),
    .ERR_LOAD(ld), .STATUS_INDICATOR_RED(red), .STATUS_INDICATOR_YELLOW(yel),
    .CODE_ACTIVE(act), .CODE_REJECT(rej)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_col(input sls_colour_t exp, input string m);
    total_checks++;
    if ({red, yel} !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic ld_num(input logic [6:0] n);
    num = n;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
  endtask

  task automatic t_modes();
    cyc(3);
    chk_col(COL_YELLOW, "ready");
    for (int i = 0; i < 3; i++) begin
      {cfg, acq, st} = 3'h1 << i;
      cyc(3);
      chk_bit(red ^ yel, 1'b1, "busy colour");
    end
    {cfg, acq, st} = 3'h0;
    cyc(3);
    chk_col(COL_YELLOW, "ready again");
    $display("test modes done");
  endtask

  task automatic t_numbers();
    logic bad;
    ev = 1'b1;
    for (int n = 0; n < 128; n++) begin
      bad = n < 11 || n > 99 || n % 10 == 0;
      ld_num(7'(n));
      chk_bit(rej, bad, "reject flag");
      cyc(2);
      chk_bit(rej, 1'b0, "reject width");
      chk_bit(act, !bad, "code shown");
    end
    $display("test numbers done");
  endtask

  task automatic t_code();
    st = 1'b1;
    ld_num(7'h1F);
    cyc(40);
    chk_col(COL_YELLOW, "separator");
    chk_bit(act, 1'b1, "code over busy");
    ld_num(7'h3A);
    cyc(3);
    chk_col(COL_YELLOW, "reload");
    ev = 1'b0;
    cyc(3);
    chk_bit(act, 1'b0, "code dropped");
    chk_bit(red ^ yel, 1'b1, "busy back");
    st = 1'b0;
    $display("test code done");
  endtask

  task automatic t_fatal();
    ev = 1'b1;
    cfg = 1'b1;
    ld_num(7'h63);
    fat = 1'b1;
    cyc(3);
    chk_col(COL_RED, "fatal");
    fat = 1'b0;
    cfg = 1'b0;
    ev = 1'b0;
    cyc(3);
    chk_col(COL_YELLOW, "after fatal");
    $display("test fatal done");
  endtask

  // Reset in mid-run must forget the stored code
  task automatic t_rerun();
    ev = 1'b1;
    ld_num(7'h0B);
    cyc(3);
    chk_bit(act, 1'b1, "code before reset");
    rst = 1'b1;
    cyc(2);
    chk_col(COL_OFF, "colour in reset");
    chk_bit(act, 1'b0, "code in reset");
    rst = 1'b0;
    cyc(2);
    chk_col(COL_YELLOW, "ready after reset");
    chk_bit(act, 1'b0, "code cleared by reset");
    ev = 1'b0;
    $display("test second reset done");
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rst, st, acq, cfg, fat, ev, ld} = 7'h40;
    num = 7'h00;
    cyc(10);
    chk_col(COL_OFF, "reset colour");
    chk_bit(act, 1'b0, "reset code flag");
    chk_bit(rej, 1'b0, "reset reject flag");
    $display("test reset done");
    rst = 1'b0;
    t_modes();
    t_numbers();
    t_code();
    t_fatal();
    t_rerun();
    close_out();
  end

  // Whole run is about 500 cycles
  initial begin
    #(40 * 2000);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
